/* File: core/servo_device.sv */
// Notes on behaviour
// - Servos come up disabled after reset
// - Reset restores configuration from non-volatile copy
// - Store command saves whole configuration
// - Enable command starts closed-loop heater drive; heater output here is enable gated by cutoff and open sensor only
// - Sensor select accepts only channel 1 or 2
// - Curve map per channel; curve id query
// - Setpoint command stores regulation target
// - Heater cut above cutoff temperature
// - Servo word: enable, sensor, alarm, on-target
// - Open sensor sets bit 5, disables servo
// - Sticky limit, current, driver faults until enable
// - Servo word: integrator bit 7, range bit 10
// - Board word bits 0 to 4
// - Board word pressure alarm and gauge type
// - Supply-high bit 7 sticky until enable
// - Board bits 8, 9 mirror drain outputs
// - Board bits 10 to 13 attachment flags
// - Commands are 24-bit ASCII words
// - Set commands reply done or error word
// - Factory targets, alarm, cutoff, window, range
// - Factory coefficients, ramp, sensor channels
// - Factory indicators, page, filter settings
// - Trigger drives alarm output, heater unaffected
//
// Our own choices: the APB register port and the placing of the registers.
module servo_device (
    input wire logic clk_in,
    input wire logic nrst_in,
    servo_link_if.device_mp link,
    input wire logic [1:0][31:0] temp_mk_in,
    input wire logic [1:0][31:0] heater_ma_in,
    input wire logic [1:0] sensor_open_in,
    input wire logic [1:0] heater_current_fault_in,
    input wire logic [1:0] driver_hot_in,
    input wire logic [1:0] integrator_active_in,
    input wire logic backplane_link_in,
    input wire logic aux_supply_in,
    input wire logic curve_mem_in,
    input wire logic watchdog_fault_in,
    input wire logic pressure_alarm_in,
    input wire logic gauge_type_in,
    input wire logic supply_high_in,
    input wire logic drain_out_first_in,
    input wire logic drain_out_second_in,
    input wire logic display_attached_in,
    input wire logic current_sense_first_in,
    input wire logic current_sense_second_in,
    input wire logic host_attached_in,
    output logic [1:0] heater_on_out,
    output logic [1:0] alarm_out,
    output logic [1:0] heater_low_range_out
);
    import servo_pkg::*;

    typedef enum logic [1:0] {RESTORE, IDLE, HOLD} dev_state_t;

    dev_state_t state;
    logic [31:0] cfg [CFG_WORDS];
    logic [31:0] nvm [CFG_WORDS];
    logic [20:0] sync1;
    logic [20:0] sync2;
    logic [1:0] enabled;
    logic [1:0] limit_st;
    logic [1:0] current_st;
    logic [1:0] hot_st;
    logic supply_high_st;
    logic [1:0][10:0] servo_word;
    logic [13:0] board_word;
    logic [1:0] above_cut;
    logic [1:0] above_trig;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    wire [20:0] raw_flags = {host_attached_in, current_sense_second_in,
        current_sense_first_in, display_attached_in, drain_out_second_in,
        drain_out_first_in, supply_high_in, gauge_type_in,
        pressure_alarm_in, watchdog_fault_in, curve_mem_in, aux_supply_in,
        backplane_link_in, integrator_active_in, driver_hot_in,
        heater_current_fault_in, sensor_open_in};
    wire [1:0] open_s = sync2[1:0];
    wire [1:0] curr_s = sync2[3:2];
    wire [1:0] hot_s = sync2[5:4];
    wire [1:0] integ_s = sync2[7:6];
    wire [12:0] board_s = sync2[20:8];

    // Two stages per flag; stage one feeds stage two only
    genvar g;
    generate
        for (g = 0; g < 21; g++) begin : g_sync
            always_ff @(posedge clk_in) begin
                sync1[g] <= raw_flags[g];
                sync2[g] <= sync1[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire take = (state == IDLE) && link.req;
    wire [31:0] a1 = link.arg1;
    wire [31:0] a2 = link.arg2;
    wire srv_ok = (a1 == 32'h1) || (a1 == 32'h2);
    wire chan_ok = (a1 >= 32'h1) && (a1 <= 32'h4);
    wire sidx = (a1 == 32'h2);
    wire [4:0] chan_off = {3'h0, 2'(a1[1:0] - 2'h1)};
    wire [4:0] srv_base = sidx ? SERVO_WORDS : 5'h00;

    logic fld_ok;
    logic is_chan;
    logic val_ok;
    logic [4:0] fld_off;

    // Parameter name to word offset and argument range
    always_comb begin
        fld_ok = 1'b1;
        is_chan = 1'b0;
        val_ok = 1'b1;
        fld_off = F_TARGET;
        case (link.sub)
            SETPOINT_CMD: fld_off = F_TARGET;
            TRIGGER_PARAM: fld_off = F_TRIGGER;
            CUTOFF_TEMP_PARAM: fld_off = F_CUTOFF;
            PROPORTIONAL_PARAM: fld_off = F_PROP;
            INTEGRAL_PARAM: begin
                fld_off = F_INTEG;
                val_ok = a2 <= INTEG_MAX;
            end
            WINDOW_PARAM: fld_off = F_WINDOW;
            RAMP_RATE_PARAM: fld_off = F_RAMP;
            SENSOR_SELECT_CMD: begin
                fld_off = F_SENSOR;
                val_ok = (a2 == 32'h1) || (a2 == 32'h2);
            end
            HEATER_RANGE_PARAM: begin
                fld_off = F_RANGE;
                val_ok = a2 <= 32'h1;
            end
            FILTER_PARAM: begin
                is_chan = 1'b1;
                fld_off = FILTER_BASE;
                val_ok = a2 <= FILTER_MAX;
            end
            CURVE_MAP_PARAM: begin
                is_chan = 1'b1;
                fld_off = CURVE_BASE;
                val_ok = a2 <= CURVE_MAX;
            end
            default: fld_ok = 1'b0;
        endcase
    end

    wire arg_ok = is_chan ? chan_ok : srv_ok;
    wire [4:0] cfg_addr = is_chan ? 5'(fld_off + chan_off)
                                  : 5'(srv_base + fld_off);
    wire set_ok = fld_ok && arg_ok && val_ok;

    logic [31:0] next_reply;
    logic do_write;
    logic do_save;
    logic do_on;
    logic do_off;

    // Reply and side effects; anything unknown leaves config alone
    always_comb begin
        next_reply = ERROR_REPLY;
        do_write = 1'b0;
        do_save = 1'b0;
        do_on = 1'b0;
        do_off = 1'b0;
        case (link.cmd)
            SET_WORD: begin
                if (set_ok) begin
                    do_write = 1'b1;
                    next_reply = DONE_REPLY;
                end
            end
            GET_WORD: begin
                if (fld_ok && arg_ok) next_reply = cfg[cfg_addr];
            end
            SERVO_ON_CMD: begin
                do_on = srv_ok;
                if (srv_ok) next_reply = DONE_REPLY;
            end
            SERVO_OFF_CMD: begin
                do_off = srv_ok;
                if (srv_ok) next_reply = DONE_REPLY;
            end
            STORE_CONFIG_CMD: begin
                do_save = 1'b1;
                next_reply = DONE_REPLY;
            end
            SERVO_STATE_QUERY: begin
                if (srv_ok) next_reply = {21'h0, servo_word[sidx]};
            end
            BOARD_STATE_QUERY: next_reply = {18'h0, board_word};
            CURVE_ID_QUERY: begin
                if (a1 <= CURVE_MAX) begin
                    next_reply = {8'h00, CURVE_ID_PREFIX,
                                  8'(8'h30 + a1[7:0])};
                end
            end
            HEATER_CURRENT_QUERY: begin
                if (srv_ok) next_reply = heater_ma_in[sidx];
            end
            default: next_reply = ERROR_REPLY;
        endcase
    end

    // ------------------------------------------------------------
    // Link handshake and configuration store
    // ------------------------------------------------------------
    // Wait for req to fall so a held request is not taken twice
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state <= RESTORE;
            link.rsp_valid <= 1'b0;
            link.rsp_data <= 32'h0;
        end else begin
            link.rsp_valid <= 1'b0;
            case (state)
                RESTORE: state <= IDLE;
                IDLE: begin
                    if (take) begin
                        state <= HOLD;
                        link.rsp_valid <= 1'b1;
                        link.rsp_data <= next_reply;
                    end
                end
                HOLD: if (!link.req) state <= IDLE;
                default: state <= RESTORE;
            endcase
        end
    end

    // Non-volatile copy starts at factory values, survives reset
    initial begin
        for (int i = 0; i < CFG_WORDS; i++)
            nvm[i] = factory_word(i);
    end

    always @(posedge clk_in) begin
        if (take && do_save) begin
            for (int i = 0; i < CFG_WORDS; i++) nvm[i] <= cfg[i];
        end
    end

    // Live copy reloads in the first cycle after reset
    always_ff @(posedge clk_in) begin
        if (state == RESTORE) begin
            for (int i = 0; i < CFG_WORDS; i++) cfg[i] <= nvm[i];
        end else if (take && do_write) begin
            cfg[cfg_addr] <= a2;
        end
    end

    // ------------------------------------------------------------
    // Per-servo supervision
    // ------------------------------------------------------------
    generate
        for (g = 0; g < 2; g++) begin : g_servo
            localparam logic [4:0] BASE = (g == 0) ? 5'h00 : SERVO_WORDS;
            wire sel2 = cfg[BASE + F_SENSOR] == 32'h2;
            wire [31:0] t = temp_mk_in[sel2];
            wire [31:0] tgt = cfg[BASE + F_TARGET];
            wire [31:0] err = (t > tgt) ? t - tgt : tgt - t;
            wire hit = take && (sidx == g);
            wire clr = hit && do_on;
            assign above_cut[g] = t > cfg[BASE + F_CUTOFF];
            assign above_trig[g] = t > cfg[BASE + F_TRIGGER];
            assign servo_word[g] = {cfg[BASE + F_RANGE][0], hot_st[g],
                current_st[g], integ_s[g], err < ON_TARGET_MK,
                open_s[g], 1'b0, above_trig[g], limit_st[g], sel2,
                enabled[g]};

            // Faults set even in the cycle of a re-enable
            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    enabled[g] <= 1'b0;
                    limit_st[g] <= 1'b0;
                    current_st[g] <= 1'b0;
                    hot_st[g] <= 1'b0;
                    heater_on_out[g] <= 1'b0;
                    alarm_out[g] <= 1'b0;
                    heater_low_range_out[g] <= 1'b0;
                end else begin
                    if (open_s[g]) enabled[g] <= 1'b0;
                    else if (clr) enabled[g] <= 1'b1;
                    else if (hit && do_off) enabled[g] <= 1'b0;
                    limit_st[g] <= above_cut[g] | (limit_st[g] & ~clr);
                    current_st[g] <= curr_s[g] | (current_st[g] & ~clr);
                    hot_st[g] <= hot_s[g] | (hot_st[g] & ~clr);
                    heater_on_out[g] <= enabled[g] & ~above_cut[g]
                                        & ~open_s[g];
                    alarm_out[g] <= above_trig[g];
                    heater_low_range_out[g] <= cfg[BASE + F_RANGE][0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Board status
    // ------------------------------------------------------------
    wire any_on = take && do_on && srv_ok;

    // Over-voltage latches until any servo is re-enabled
    always_ff @(posedge clk_in) begin
        if (!nrst_in) supply_high_st <= 1'b0;
        else supply_high_st <= board_s[6] | (supply_high_st & ~any_on);
    end

    assign board_word = {board_s[12:7], supply_high_st, board_s[5:4],
                         cfg[LED_IDX][0], board_s[3:0]};

endmodule // servo_device

/* File: core/servo_pkg.sv */
package servo_pkg;

    // ------------------------------------------------------------
    // Command words: three ASCII letters, first letter in the MSB
    // ------------------------------------------------------------
    localparam logic [23:0] SET_WORD = 24'h534554;
    localparam logic [23:0] GET_WORD = 24'h474554;
    localparam logic [23:0] SERVO_ON_CMD = 24'h454e41;
    localparam logic [23:0] SERVO_OFF_CMD = 24'h444953;
    localparam logic [23:0] STORE_CONFIG_CMD = 24'h534156;
    localparam logic [23:0] SERVO_STATE_QUERY = 24'h475353;
    localparam logic [23:0] BOARD_STATE_QUERY = 24'h535953;
    localparam logic [23:0] CURVE_ID_QUERY = 24'h544349;
    localparam logic [23:0] HEATER_CURRENT_QUERY = 24'h484355;
    localparam logic [23:0] SETPOINT_CMD = 24'h544152;
    localparam logic [23:0] TRIGGER_PARAM = 24'h545247;
    localparam logic [23:0] CUTOFF_TEMP_PARAM = 24'h4c494d;
    localparam logic [23:0] PROPORTIONAL_PARAM = 24'h50524f;
    localparam logic [23:0] INTEGRAL_PARAM = 24'h494e54;
    localparam logic [23:0] WINDOW_PARAM = 24'h495749;
    localparam logic [23:0] RAMP_RATE_PARAM = 24'h534c4f;
    localparam logic [23:0] SENSOR_SELECT_CMD = 24'h53454e;
    localparam logic [23:0] HEATER_RANGE_PARAM = 24'h484c50;
    localparam logic [23:0] FILTER_PARAM = 24'h46494c;
    localparam logic [23:0] CURVE_MAP_PARAM = 24'h4d4150;
    localparam logic [31:0] DONE_REPLY = 32'h00444f4e;
    localparam logic [31:0] ERROR_REPLY = 32'h00455252;

    // ------------------------------------------------------------
    // Configuration word layout (one servo block per servo)
    // ------------------------------------------------------------
    localparam logic [4:0] F_TARGET = 5'h00;
    localparam logic [4:0] F_TRIGGER = 5'h01;
    localparam logic [4:0] F_CUTOFF = 5'h02;
    localparam logic [4:0] F_PROP = 5'h03;
    localparam logic [4:0] F_INTEG = 5'h04;
    localparam logic [4:0] F_WINDOW = 5'h05;
    localparam logic [4:0] F_RAMP = 5'h06;
    localparam logic [4:0] F_SENSOR = 5'h07;
    localparam logic [4:0] F_RANGE = 5'h08;
    localparam logic [4:0] SERVO_WORDS = 5'h09;
    localparam logic [4:0] FILTER_BASE = 5'h12;
    localparam logic [4:0] CURVE_BASE = 5'h16;
    localparam logic [4:0] LED_IDX = 5'h1a;
    localparam logic [4:0] PAGE_IDX = 5'h1b;
    localparam int CFG_WORDS = 28;

    // ------------------------------------------------------------
    // Factory values and argument limits
    // ------------------------------------------------------------
    localparam logic [31:0] FACT_TARGET_MK = 32'h00027100;  // 160 K
    localparam logic [31:0] FACT_TRIGGER_MK = 32'h00029810; // 170 K
    localparam logic [31:0] FACT_CUTOFF_MK = 32'h0004a768;  // 305 K
    localparam logic [31:0] FACT_PROP = 32'h000000c8;       // 200
    localparam logic [31:0] FACT_INTEG = 32'h00000050;      // 80
    localparam logic [31:0] FACT_WINDOW_MK = 32'h00002710;  // 10 K
    localparam logic [31:0] FACT_RAMP = 32'h00001194;       // 4.5 K/min
    localparam logic [31:0] FACT_RANGE = 32'h00000000;      // high power
    localparam logic [31:0] FACT_FILTER = 32'h00000003;     // 0.1 Hz code
    localparam logic [31:0] FACT_CURVE = 32'h00000000;
    localparam logic [31:0] FACT_LED = 32'h00000001;
    localparam logic [31:0] FACT_PAGE = 32'h00000001;
    localparam logic [31:0] INTEG_MAX = 32'h000003e8;
    localparam logic [31:0] FILTER_MAX = 32'h00000003;
    localparam logic [31:0] CURVE_MAX = 32'h0000000f;
    localparam logic [31:0] ON_TARGET_MK = 32'h000003e8;    // 1 K
    localparam logic [15:0] CURVE_ID_PREFIX = 16'h4356;     // arbitrary

    // ------------------------------------------------------------
    // Servo and board status bit positions
    // ------------------------------------------------------------
    localparam int SS_ENABLE = 0;
    localparam int SS_SENSOR = 1;
    localparam int SS_LIMIT = 2;
    localparam int SS_ALARM = 3;
    localparam int SS_OPEN = 5;
    localparam int SS_ON_TARGET = 6;
    localparam int SS_INTEG = 7;
    localparam int SS_CURRENT = 8;
    localparam int SS_HOT = 9;
    localparam int SS_RANGE = 10;
    localparam int BS_LED = 4;
    localparam int BS_SUPPLY_HIGH = 7;

    // ------------------------------------------------------------
    // Host command registers on APB
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_SUB = 8'h04;
    localparam logic [7:0] REG_ARG1 = 8'h08;
    localparam logic [7:0] REG_ARG2 = 8'h0c;
    localparam logic [7:0] REG_CTRL = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_REPLY = 8'h18;

    function automatic logic [31:0] factory_word(input int idx);
        logic [31:0] w;
        w = 32'h0;
        if (idx < 18) begin
            case (idx % 9)
                0: w = FACT_TARGET_MK;
                1: w = FACT_TRIGGER_MK;
                2: w = FACT_CUTOFF_MK;
                3: w = FACT_PROP;
                4: w = FACT_INTEG;
                5: w = FACT_WINDOW_MK;
                6: w = FACT_RAMP;
                7: w = (idx < 9) ? 32'h1 : 32'h2;
                default: w = FACT_RANGE;
            endcase
        end else if (idx < 22) begin
            w = FACT_FILTER;
        end else if (idx < 26) begin
            w = FACT_CURVE;
        end else if (idx == 26) begin
            w = FACT_LED;
        end else begin
            w = FACT_PAGE;
        end
        return w;
    endfunction

endpackage

/* File: core/servo_link_if.sv */
// Four-phase command link: req held until reply, then dropped
interface servo_link_if (
    input wire logic clk_in
);
    logic req;
    logic [23:0] cmd;
    logic [23:0] sub;
    logic [31:0] arg1;
    logic [31:0] arg2;
    logic rsp_valid;
    logic [31:0] rsp_data;

    modport device_mp (
        input req, cmd, sub, arg1, arg2,
        output rsp_valid, rsp_data
    );
    modport host_mp (
        output req, cmd, sub, arg1, arg2,
        input rsp_valid, rsp_data
    );
endinterface

/* File: core/servo_host.sv */
// Host end: APB command registers driving the four-phase link
module servo_host (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    servo_link_if.host_mp link
);
    import servo_pkg::*;

    logic busy;
    logic done;
    logic [31:0] reply;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // One wait state so prdata and pslverr can be registered
    wire setup_done = psel && penable && !pready;
    wire commit = psel && penable && pready;
    wire wr = commit && pwrite;
    wire mapped = (paddr <= REG_REPLY) && (paddr[1:0] == 2'h0);
    wire wr_args = wr && !busy && mapped;
    wire start = wr_args && (paddr == REG_CTRL) && pwdata[0];
    wire done_clr = wr && (paddr == REG_STATUS) && pwdata[1];

    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            REG_CMD: rd_mux = {8'h00, link.cmd};
            REG_SUB: rd_mux = {8'h00, link.sub};
            REG_ARG1: rd_mux = link.arg1;
            REG_ARG2: rd_mux = link.arg2;
            REG_STATUS: rd_mux = {30'h0, done, busy};
            REG_REPLY: rd_mux = reply;
            default: rd_mux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_done;
            pslverr <= setup_done && !mapped;
            if (setup_done) prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Command registers and link
    // ------------------------------------------------------------
    // Arguments frozen while a command is on the link
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            link.cmd <= 24'h0;
            link.sub <= 24'h0;
            link.arg1 <= 32'h0;
            link.arg2 <= 32'h0;
        end else if (wr_args) begin
            if (paddr == REG_CMD) link.cmd <= pwdata[23:0];
            if (paddr == REG_SUB) link.sub <= pwdata[23:0];
            if (paddr == REG_ARG1) link.arg1 <= pwdata;
            if (paddr == REG_ARG2) link.arg2 <= pwdata;
        end
    end

    // Done set by the reply wins over a software clear
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            busy <= 1'b0;
            done <= 1'b0;
            reply <= 32'h0;
        end else begin
            if (link.rsp_valid) begin
                busy <= 1'b0;
                reply <= link.rsp_data;
            end else if (start) begin
                busy <= 1'b1;
            end
            done <= (busy && link.rsp_valid) | (done & ~done_clr);
        end
    end

    assign link.req = busy;

endmodule // servo_host

/* File: testbench/servo_assertions.sv */
// ----
// Link reply checker
// ----
module servo_assertions
    import servo_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic req,
    input wire logic [23:0] cmd,
    input wire logic [23:0] sub,
    input wire logic [31:0] arg1,
    input wire logic [31:0] arg2,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_data
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // Reply classes, only meaningful while a reply stands
    wire ok = rsp_valid && rsp_data == DONE_REPLY;
    wire bad = rsp_valid && rsp_data == ERROR_REPLY;
    a_reply_follows: assert property ($rose(req) |=> rsp_valid)
        else $error("late reply");
    a_pulse_once: assert property (rsp_valid |=> !rsp_valid)
        else $error("long reply");
    a_reply_in_req: assert property (rsp_valid |-> req)
        else $error("stray reply");
    a_data_holds: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("reply data moved");
    a_set_reply: assert property (rsp_valid && cmd == SET_WORD
        |-> ok || bad)
        else $error("bad set reply");
    a_sensor_range: assert property (rsp_valid && cmd == SET_WORD
        && sub == SENSOR_SELECT_CMD && !(arg2 inside {1, 2}) |-> bad)
        else $error("sensor range");
    a_store_done: assert property (rsp_valid && cmd == STORE_CONFIG_CMD
        |-> ok)
        else $error("store reply");
    a_curve_ident: assert property (rsp_valid && cmd == CURVE_ID_QUERY
        && arg1 < 32'h10 |-> rsp_data[23:0] ==
        {CURVE_ID_PREFIX, 8'h30 + arg1[7:0]})
        else $error("curve id");
endmodule // servo_assertions

/* File: testbench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import servo_pkg::*;
    // ----
    // Stimulus, the two ends and the checker
    // ----
    logic clk_in = 1'b0, nrst_in = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [1:0][31:0] t = '0;
    logic [1:0] so = 2'h0, hf = 2'h0, dh = 2'h0, ia = 2'h0, hon, alm, lr;
    logic [13:0] bf = 14'h0;
    int err_total = 0, tests_run = 0;
    logic [23:0] pc [9] = '{SETPOINT_CMD, TRIGGER_PARAM, CUTOFF_TEMP_PARAM,
        PROPORTIONAL_PARAM, INTEGRAL_PARAM, WINDOW_PARAM, RAMP_RATE_PARAM,
        SENSOR_SELECT_CMD, HEATER_RANGE_PARAM};
    logic [31:0] fv [9] = '{32'h27100, 32'h29810, 32'h4a768, 32'hc8,
        32'h50, 32'h2710, 32'h1194, 32'h0, 32'h0};
    // 2.5 ns half period
    always #2.5 clk_in = ~clk_in;
    servo_link_if lk (.clk_in);
    servo_host servo_host_inst (.clk_in, .nrst_in, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link(lk));
    servo_device servo_device_inst (.clk_in, .nrst_in, .link(lk),
        .temp_mk_in(t), .heater_ma_in(t), .sensor_open_in(so),
        .heater_current_fault_in(hf), .driver_hot_in(dh),
        .integrator_active_in(ia), .backplane_link_in(bf[0]),
        .aux_supply_in(bf[1]), .curve_mem_in(bf[2]),
        .watchdog_fault_in(bf[3]), .pressure_alarm_in(bf[5]),
        .gauge_type_in(bf[6]), .supply_high_in(bf[7]),
        .drain_out_first_in(bf[8]), .drain_out_second_in(bf[9]),
        .display_attached_in(bf[10]), .current_sense_first_in(bf[11]),
        .current_sense_second_in(bf[12]), .host_attached_in(bf[13]),
        .heater_on_out(hon), .alarm_out(alm), .heater_low_range_out(lr));
    servo_assertions sva (.clk_in, .nrst_in, .req(lk.req), .cmd(lk.cmd),
        .sub(lk.sub), .arg1(lk.arg1), .arg2(lk.arg2),
        .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data));
    // ----
    // Tasks
    // ----
    task automatic summarize;
        $display("tests %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // A missing answer ends the run rather than hanging it
    task automatic hang(input logic fine);
        if (!fine) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic rst;
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 9);
        hang(pready === 1'b1);
        q = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk_in);
    endtask
    // Whole command round trip, done flag cleared before the start
    task automatic cmd(input logic [23:0] c, input logic [23:0] s,
        input logic [31:0] a1, input logic [31:0] a2, input logic [31:0] e);
        int n;
        n = 0;
        apb(1'b1, REG_CMD, {8'h00, c});
        apb(1'b1, REG_SUB, {8'h00, s});
        apb(1'b1, REG_ARG1, a1);
        apb(1'b1, REG_ARG2, a2);
        apb(1'b1, REG_STATUS, 32'h2);
        apb(1'b1, REG_CTRL, 32'h1);
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (q[1] !== 1'b1 && n < 9);
        hang(q[1] === 1'b1);
        apb(1'b0, REG_REPLY, 32'h0);
        chk(q, e);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        rst();
        chk(32'({hon, alm, lr}), 32'h0);
        for (int s = 1; s < 3; s++) begin
            for (int i = 0; i < 9; i++) begin
                cmd(GET_WORD, pc[i], s, 0, i == 7 ? s : fv[i]);
            end
        end
        bf <= 14'h2a8b;
        cmd(BOARD_STATE_QUERY, '0, 0, 0, 32'h2a9b);
        bf <= 14'h1544;
        cmd(BOARD_STATE_QUERY, '0, 0, 0, 32'h15d4);
        cmd(SET_WORD, SENSOR_SELECT_CMD, 1, 3, ERROR_REPLY);
        cmd(SET_WORD, SENSOR_SELECT_CMD, 1, 2, DONE_REPLY);
        cmd(SET_WORD, SETPOINT_CMD, 1, 32'h26930, DONE_REPLY);
        cmd(STORE_CONFIG_CMD, '0, 0, 0, DONE_REPLY);
        cmd(SET_WORD, SETPOINT_CMD, 1, 32'h1, DONE_REPLY);
        rst();
        cmd(GET_WORD, SETPOINT_CMD, 1, 0, 32'h26930);
        t[1] <= 32'h26930;
        cmd(SERVO_STATE_QUERY, '0, 1, 0, 32'h42);
        cmd(SERVO_ON_CMD, '0, 1, 0, DONE_REPLY);
        chk(32'(hon), 32'h1);
        t[1] <= 32'h30d40;
        cmd(SERVO_STATE_QUERY, '0, 1, 0, 32'hb);
        chk(32'({hon, alm}), 32'h7);
        t[1] <= 32'h61a80;
        cmd(SERVO_STATE_QUERY, '0, 1, 0, 32'hf);
        chk(32'(hon), 32'h0);
        t[1] <= 32'h26930;
        cmd(SERVO_STATE_QUERY, '0, 1, 0, 32'h47);
        cmd(SERVO_ON_CMD, '0, 1, 0, DONE_REPLY);
        cmd(SERVO_STATE_QUERY, '0, 1, 0, 32'h43);
        {so, hf, dh, ia} <= 8'h55;
        cmd(SERVO_STATE_QUERY, '0, 1, 0, 32'h3e2);
        chk(32'(hon), 32'h0);
        cmd(CURVE_ID_QUERY, '0, 5, 0, {8'h00, CURVE_ID_PREFIX, 8'h35});
        cmd(SET_WORD, HEATER_RANGE_PARAM, 2, 1, DONE_REPLY);
        chk(32'(lr), 32'h2);
        cmd(GET_WORD, FILTER_PARAM, 4, 0, FACT_FILTER);
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(perr), 32'h1);
        summarize();
    end
endmodule // tb
